// File: ccr_ch1_config.sv
// Channel 1 configuration register with APB slave and decoded controls.
// Assumes APB master in mclk_in domain; analog routing acts on outputs.
// How it works
// - Bits 15:6 hold signed phase delay, reset zero
// - Bit 2 set disables channel 1 DC block
// - Bit 2 clear follows global DC setting
// - Select 00 routes own input pins, reset 00
// - Select 01 shorts converter inputs together
// - Select 10/11 apply positive/negative test signal
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module ccr_ch1_config (
    input  wire logic                mclk_in,          // 40 MHz clock
    input  wire logic                srst_in,          // Sync reset, high
    input  wire logic                psel_in,          // APB select
    input  wire logic                penable_in,       // APB enable
    input  wire logic                pwrite_in,        // APB write
    input  wire logic [11:0]         paddr_in,         // APB byte address
    input  wire logic [31:0]         pwdata_in,        // APB write data
    input  wire logic [3:0]          pstrb_in,         // APB byte strobes
    input  wire logic [3:0]          global_dc_block_setting_in, // Shared
    output logic                     pready_out,       // APB ready
    output logic                     pslverr_out,      // APB error
    output logic [31:0]              prdata_out,       // APB read data
    output logic signed [9:0]        ch1_phase_delay_out, // Cycles
    output logic [3:0]               ch1_dc_block_out, // Effective DC
    output ccr_pkg::ccr_route_s      ch1_route_out     // Input routing
);
    logic [15:0] channel1_config;
    logic [15:0] next_channel1_config;
    logic        access;
    logic        hit;
    logic [1:0]  sel_field;

    assign access = psel_in && penable_in && !pready_out;
    assign hit    = (paddr_in == ccr_pkg::CHANNEL1_CONFIG_ADDR);
    assign sel_field = channel1_config[ccr_pkg::SEL_MSB:ccr_pkg::SEL_LSB];

    // Byte strobes merge; reserved bits forced low
    always_comb begin
        next_channel1_config = channel1_config;
        if (pstrb_in[0]) begin
            next_channel1_config[7:0] = pwdata_in[7:0];
        end
        if (pstrb_in[1]) begin
            next_channel1_config[15:8] = pwdata_in[15:8];
        end
        next_channel1_config = next_channel1_config
                             & ccr_pkg::CFG_WRITE_MASK;
    end

    // One wait state: ready rises in the access cycle after entry
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= access;
            pslverr_out <= access && !hit;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            channel1_config <= ccr_pkg::CFG_RESET;
        end else if (access && hit && pwrite_in) begin
            channel1_config <= next_channel1_config;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (access && !pwrite_in) begin
            if (hit) begin
                prdata_out <= {16'h0000, channel1_config};
            end else begin
                prdata_out <= 32'h0000_0000;
            end
        end
    end

    // Decoded controls registered so every output leaves a flop
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ch1_phase_delay_out <= 10'sh000;
            ch1_dc_block_out    <= 4'h0;
            ch1_route_out       <= '{1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            ch1_phase_delay_out <= signed'(channel1_config[
                ccr_pkg::PHASE_MSB:ccr_pkg::PHASE_LSB]);
            if (channel1_config[ccr_pkg::DCOFF_BIT]) begin
                ch1_dc_block_out <= 4'h0;
            end else begin
                ch1_dc_block_out <= global_dc_block_setting_in;
            end
            ch1_route_out.pins_on <= sel_field
                == ccr_pkg::CCR_SEL_PINS;
            ch1_route_out.short_on <= sel_field
                == ccr_pkg::CCR_SEL_SHORT;
            ch1_route_out.pos_test_on <= sel_field
                == ccr_pkg::CCR_SEL_POS_TEST;
            ch1_route_out.neg_test_on <= sel_field
                == ccr_pkg::CCR_SEL_NEG_TEST;
        end
    end

    // Field decode checks; each output lags the register by one cycle

    a_reset_value: assert property (@(posedge mclk_in)
        srst_in |=> channel1_config == 16'h0000)
        else $error("config not zero after reset");
    a_reserved_zero: assert property (@(posedge mclk_in)
        disable iff (srst_in) channel1_config[5:3] == 3'h0)
        else $error("reserved bits nonzero");
    a_phase_out: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        ##1 ch1_phase_delay_out == $past(channel1_config[15:6]))
        else $error("phase output mismatch");
    a_dc_off: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        channel1_config[2] |=> ch1_dc_block_out == 4'h0)
        else $error("dc block not disabled");
    // Sampled reset keeps out the release edge: output still idle there
    a_dc_follow: assert property (@(posedge mclk_in)
        disable iff (srst_in) !srst_in && !channel1_config[2]
        |=> ch1_dc_block_out == $past(global_dc_block_setting_in))
        else $error("dc block not following global");
    a_sel_pins: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        channel1_config[1:0] == 2'h0 |=> ch1_route_out.pins_on
        && !ch1_route_out.short_on)
        else $error("pins not routed");
    a_sel_short: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        channel1_config[1:0] == 2'h1 |=> ch1_route_out.short_on
        && !ch1_route_out.pins_on)
        else $error("inputs not shorted");
    a_sel_test: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        channel1_config[1] |=> (ch1_route_out.pos_test_on
        != ch1_route_out.neg_test_on) && !ch1_route_out.pins_on)
        else $error("test signal select wrong");
    a_write_lands: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        access && hit && pwrite_in && pstrb_in == 4'hF
        |=> channel1_config == ($past(pwdata_in[15:0]) & 16'hFFC7))
        else $error("write not stored");

    // Every decoded output returns to its idle value under reset
    a_reset_outputs: assert property (@(posedge mclk_in)
        srst_in |=> ch1_route_out.pins_on && !ch1_route_out.short_on
        && ch1_phase_delay_out == 10'sh000 && ch1_dc_block_out == 4'h0
        && !pready_out && !pslverr_out)
        else $error("outputs not idle after reset");

    // Bus handshake: one wait state, ready lasts one cycle
    a_ready_follows: assert property (@(posedge mclk_in)
        disable iff (srst_in) access |=> pready_out)
        else $error("ready did not follow access");

    a_ready_pulse: assert property (@(posedge mclk_in)
        disable iff (srst_in) pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");

    a_ready_cause: assert property (@(posedge mclk_in)
        disable iff (srst_in) pready_out |-> $past(access))
        else $error("ready without an access");

    // Unmapped offsets answer with an error and change nothing
    a_err_unmapped: assert property (@(posedge mclk_in)
        disable iff (srst_in) access && !hit |=> pslverr_out)
        else $error("no error for unmapped offset");

    a_err_mapped: assert property (@(posedge mclk_in)
        disable iff (srst_in) access && hit |=> !pslverr_out)
        else $error("error on mapped offset");

    a_err_pulse: assert property (@(posedge mclk_in)
        disable iff (srst_in) pslverr_out |-> pready_out)
        else $error("error without ready");

    a_unmapped_keep: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        access && !hit |=> $stable(channel1_config))
        else $error("unmapped access changed config");

    // Only a mapped write may move the register
    a_idle_keep: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        !(access && hit && pwrite_in) |=> $stable(channel1_config))
        else $error("config changed without a write");

    // Unstrobed upper lane keeps its bits
    a_lane_keep: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        access && hit && pwrite_in && !pstrb_in[1]
        |=> channel1_config[15:8] == $past(channel1_config[15:8]))
        else $error("unstrobed lane overwritten");

    // Reads return the register; upper half stays zero
    a_read_data: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        access && hit && !pwrite_in
        |=> prdata_out == {16'h0000, $past(channel1_config)})
        else $error("read data wrong");

    // Read data holds until the next read
    a_read_hold: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        !srst_in && !(access && !pwrite_in) |=> $stable(prdata_out))
        else $error("read data changed without a read");

    // Exactly one routing control is on at any time
    a_route_onehot: assert property (@(posedge mclk_in)
        disable iff (srst_in) $onehot(ch1_route_out))
        else $error("routing controls not one-hot");

    c_write: cover property (@(posedge mclk_in)
        access && hit && pwrite_in);
    c_read: cover property (@(posedge mclk_in)
        access && hit && !pwrite_in);
    c_bad_addr: cover property (@(posedge mclk_in) access && !hit);
    c_neg_test: cover property (@(posedge mclk_in)
        ch1_route_out.neg_test_on);
    c_dc_off: cover property (@(posedge mclk_in)
        channel1_config[ccr_pkg::DCOFF_BIT] ##1 ch1_dc_block_out == 4'h0);
endmodule

// File: ccr_ch1_config_test.sv
// Self-checking bench for the channel 1 configuration register.
// Assumes an APB slave at byte 0x038 answering after one wait state.
`timescale 1ns/100ps
module ccr_ch1_config_test;
    logic                mclk_in = 0, srst_in = 1;
    logic                psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0]         paddr_in = '0;
    logic [31:0]         pwdata_in = '0;
    logic [3:0]          pstrb_in = '0, global_dc_block_setting_in = 4'h5;
    logic                pready_out, pslverr_out, err;
    logic [31:0]         prdata_out, rd;
    logic signed [9:0]   ch1_phase_delay_out;
    logic [3:0]          ch1_dc_block_out;
    ccr_pkg::ccr_route_s ch1_route_out;
    int                  n_mismatch = 0, comparisons = 0;

    ccr_ch1_config u_ccr_ch1_config (.mclk_in, .srst_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
        .global_dc_block_setting_in, .pready_out, .pslverr_out,
        .prdata_out, .ch1_phase_delay_out, .ch1_dc_block_out,
        .ch1_route_out);

    initial forever #12.5 mclk_in = ~mclk_in;

    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk_in);
        psel_in    <= 1'b1;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        pstrb_in   <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask

    task automatic t_reset;
        apb(0, 12'h038, 0, 0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0);
        chk({28'h0, ch1_route_out}, 32'h8);
        chk({28'h0, ch1_dc_block_out}, 32'h5);
    endtask

    // Reset in mid-run must clear a register that holds data
    task automatic t_mid_reset;
        apb(1, 12'h038, 32'h0000_8046, 4'hF);
        chk({22'h0, ch1_phase_delay_out}, 32'h201);
        chk({28'h0, ch1_route_out}, 32'h2);
        chk({28'h0, ch1_dc_block_out}, 32'h0);
        srst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        apb(0, 12'h038, 0, 0);
        chk(rd, 32'h0000_0000);
        chk({22'h0, ch1_phase_delay_out}, 32'h0);
        chk({28'h0, ch1_route_out}, 32'h8);
        chk({28'h0, ch1_dc_block_out}, 32'hA);
    endtask

    task automatic t_all_ones;
        apb(1, 12'h038, 32'hFFFF_FFFF, 4'hF);
        apb(0, 12'h038, 0, 0);
        chk(rd, 32'h0000_FFC7);
        chk({22'h0, ch1_phase_delay_out}, 32'h3FF);
        chk({28'h0, ch1_dc_block_out}, 32'h0);
        chk({28'h0, ch1_route_out}, 32'h1);
    endtask

    task automatic t_select;
        global_dc_block_setting_in <= 4'hA;
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h038, i, 4'hF);
            chk({28'h0, ch1_route_out}, 32'h8 >> i);
            chk({28'h0, ch1_dc_block_out}, 32'hA);
        end
    endtask

    task automatic t_lane_unmapped;
        apb(1, 12'h038, 32'h0000_FFFF, 4'h1);
        apb(1, 12'h03C, 32'h0000_1234, 4'hF);
        apb(0, 12'h03C, 0, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(0, 12'h038, 0, 0);
        chk(rd, 32'h0000_00C7);
    endtask

    initial begin
        repeat (20) @(posedge mclk_in);
        srst_in <= 1'b0;
        t_reset();
        t_all_ones();
        t_select();
        t_lane_unmapped();
        t_mid_reset();
        finish_test();
    end

    initial begin
        repeat (2000) @(posedge mclk_in);
        n_mismatch++;
        finish_test();
    end
endmodule

// File: ccr_pkg.sv
// Package for the channel 1 configuration register block.
// Assumes a 32-bit APB master; one register at byte address 0x038.
package ccr_pkg;
    // Register index 0Eh; its byte address is four times the index
    localparam logic [7:0]  CHANNEL1_CONFIG_INDEX      = 8'h0E;
    localparam logic [11:0] CHANNEL1_CONFIG_ADDR       = 12'h038;
    localparam logic [15:0] CFG_RESET          = 16'h0000;
    localparam int          PHASE_MSB          = 15;
    localparam int          PHASE_LSB          = 6;
    localparam int          DCOFF_BIT          = 2;
    localparam int          SEL_MSB            = 1;
    localparam int          SEL_LSB            = 0;
    localparam logic [15:0] CFG_WRITE_MASK     = 16'hFFC7;

    typedef enum logic [1:0] {
        CCR_SEL_PINS,
        CCR_SEL_SHORT,
        CCR_SEL_POS_TEST,
        CCR_SEL_NEG_TEST
    } ccr_sel_e;

    // Analog routing controls for channel 1
    typedef struct packed {
        logic pins_on;
        logic short_on;
        logic pos_test_on;
        logic neg_test_on;
    } ccr_route_s;
endpackage
